// ### src/smc_top.sv
// stepper controller pin interface: straps, serial port, step/dir, flags
// Notes on behaviour
// - The three protocol/address straps select protocol and address, reading 1 when open.
// - The three baud straps select the serial bit rate, reading 1 when open.
// - A low checksum strap turns off only the receive checksum error flag, high turns it on; transmit parity is always generated.
// - A low autorecall strap loads the stored program and starts it at once.
// - Commands arrive only on the serial receive line; here control and step counts are written over the register port.
// - All answers leave only on the serial transmit line; here register reads return on REG_RDATA_O.
// - The open-collector ready flag is pulled low while a command or program runs.
// - The moving flag is high during any motor movement and low at rest.
// - The ramping flag is high whenever the moving flag is high and the control ramp bit is set.
// - No step pulse is produced while the enable input is low.
// - Enable is sampled before each step so outside logic can hold off the next one.
// - Direction high means clockwise, low counterclockwise, and is stable around each step.
// - Driver reset goes low for 400 us after power-on and on each position-counter init.
// - The step clock idles high and each step is one 1.7 us low pulse.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module smc_top #(
  parameter int unsigned DRV_RST_CYC = smc_pkg::DRV_RST_CYC,
  parameter int unsigned CLK_HZ      = smc_pkg::CLK_HZ
) (
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CE_I,
  input  wire logic [2:0]  PROTO_ADDR_STRAP_I,
  input  wire logic [2:0]  BAUD_STRAP_I,
  input  wire logic        CHECKSUM_STRAP_I,
  input  wire logic        AUTORECALL_STRAP_I,
  input  wire logic        ENABLE_I,
  input  wire logic        RXD_I,
  output logic             TXD_O,
  output logic             READY_FLAG_O,
  output logic             READY_FLAG_OE_N_O,
  output logic             MOVING_FLAG_O,
  output logic             RAMPING_FLAG_O,
  output logic             DIR_O,
  output logic             DRV_RST_N_O,
  output logic             STEP_CLK_O,
  output logic             AUTORECALL_START_O,
  output logic             IRQ_O,
  input  wire logic [3:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic [31:0]      REG_RDATA_O
);

  // refuse counts that the 24-bit reset counter, the 17-bit baud divider or the 9-bit step counter cannot hold
  if (DRV_RST_CYC < 1 || DRV_RST_CYC > 32'h00FF_FFFF || smc_pkg::STEP_PULSE_CYC > 512
      || CLK_HZ / (smc_pkg::UART_OVS * smc_pkg::BAUD_LOW) > 32'h0001_FFFF
      || CLK_HZ / (smc_pkg::UART_OVS * smc_pkg::BAUD_HIGH) < 2) begin : g_bad_param
    $error("smc_top parameters out of range");
  end

  typedef enum logic [1:0] {
    SMC_ST_IDLE  = 2'b00,
    SMC_ST_SETUP = 2'b01,
    SMC_ST_PULSE = 2'b11,
    SMC_ST_HOLD  = 2'b10
  } smc_step_t;

  // two-stage synchronisers on the strap, enable and receive pin inputs
  logic [9:0] sync1, sync2;
  logic [9:0] pins;
  assign pins = {ENABLE_I, RXD_I, AUTORECALL_STRAP_I, CHECKSUM_STRAP_I, BAUD_STRAP_I, PROTO_ADDR_STRAP_I};
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      sync1 <= 10'h3FF;
      sync2 <= 10'h3FF;
    end else if (CE_I) begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  // strap latch and control state
  logic [1:0]  latch_cnt, next_latch_cnt;
  logic [2:0]  proto_addr, next_proto_addr;
  logic [2:0]  baud_code, next_baud_code;
  logic        cksum_en, next_cksum_en;
  logic        recall_n, next_recall_n;
  logic        next_recall_start;
  logic [3:0]  ctrl, next_ctrl;
  localparam int unsigned IRQ_W = smc_pkg::IRQ_BITS;
  logic [IRQ_W-1:0] irq_st, next_irq_st, irq_mk, next_irq_mk;
  logic [23:0] rst_cnt, next_rst_cnt;
  logic        next_drv_rst_n;
  logic [31:0] next_rdata;
  logic [6:0]  tx_data, next_tx_data;
  logic        tx_start, next_tx_start;
  logic [15:0] steps_left, next_steps_left;
  smc_step_t   st, next_st;
  logic [8:0]  st_cnt, next_st_cnt;
  logic        next_step_clk, next_dir, next_moving, next_ramping;
  logic        next_ready, next_irq;
  logic        tx_busy, rx_valid, rx_err, txd;
  logic [6:0]  rx_data;
  logic        enable_s, move_done;

  assign enable_s = sync2[9];

  smc_uart u_uart (
    .clk_i      (CLOCK_I),
    .rst_i      (SYS_RST_I),
    .ce_i       (CE_I),
    .div_i      (smc_pkg::baud_div(baud_code, CLK_HZ)),
    .rxd_i      (sync2[8]),
    .tx_start_i (tx_start),
    .tx_data_i  (tx_data),
    .txd_o      (txd),
    .tx_busy_o  (tx_busy),
    .rx_valid_o (rx_valid),
    .rx_err_o   (rx_err),
    .rx_data_o  (rx_data)
  );

  always_comb begin
    next_latch_cnt    = (latch_cnt != 2'h3) ? latch_cnt + 2'h1 : latch_cnt;
    next_proto_addr   = proto_addr;
    next_baud_code    = baud_code;
    next_cksum_en     = cksum_en;
    next_recall_n     = recall_n;
    next_recall_start = 1'b0;
    next_ctrl         = ctrl;
    next_irq_st       = irq_st;
    next_irq_mk       = irq_mk;
    next_rst_cnt      = (rst_cnt != 24'h000000) ? rst_cnt - 24'h000001 : rst_cnt;
    next_tx_data      = tx_data;
    next_tx_start     = 1'b0;
    next_steps_left   = steps_left;
    next_rdata        = 32'h0000_0000;
    // straps latched once after reset
    // synchronisers carry pin values only from the second edge after reset
    if (latch_cnt == 2'h2) begin
      next_proto_addr = sync2[2:0];
      next_baud_code  = sync2[5:3];
      next_cksum_en   = sync2[6];
      next_recall_n   = sync2[7];
      next_recall_start = !sync2[7];
    end
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        smc_pkg::REG_CTRL:   next_rdata = {28'h0000000, ctrl};
        smc_pkg::REG_STATUS: next_rdata = {24'h000000, tx_busy, DRV_RST_N_O, enable_s, RAMPING_FLAG_O,
                                           MOVING_FLAG_O, READY_FLAG_O, DIR_O, STEP_CLK_O};
        smc_pkg::REG_IRQ_ST: next_rdata = {28'h0000000, irq_st};
        smc_pkg::REG_IRQ_MK: next_rdata = {28'h0000000, irq_mk};
        smc_pkg::REG_STRAPS: next_rdata = {24'h000000, recall_n, cksum_en, baud_code, proto_addr};
        smc_pkg::REG_RXDATA: next_rdata = {25'h0000000, rx_data};
        smc_pkg::REG_STEP:   next_rdata = {16'h0000, steps_left};
        default:             next_rdata = 32'h0000_0000;
      endcase
      if (REG_ADDR_I == smc_pkg::REG_IRQ_ST) begin
        next_irq_st = '0;
      end
    end
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        smc_pkg::REG_CTRL: begin
          next_ctrl = {1'b0, REG_WDATA_I[2:0]};
          if (REG_WDATA_I[smc_pkg::CTRL_INIT_POS]) begin
            next_rst_cnt = DRV_RST_CYC[23:0];
          end
        end
        smc_pkg::REG_IRQ_MK: next_irq_mk = REG_WDATA_I[IRQ_W-1:0];
        smc_pkg::REG_TXDATA: begin
          next_tx_data  = REG_WDATA_I[6:0];
          next_tx_start = 1'b1;
        end
        smc_pkg::REG_STEP: next_steps_left = REG_WDATA_I[15:0];
        default: begin
        end
      endcase
    end
    if (st == SMC_ST_PULSE && st_cnt == 9'h000 && steps_left != 16'h0000) begin
      next_steps_left = steps_left - 16'h0001;
    end
    // events set after any clear, so the set wins
    if (rx_valid) begin
      next_irq_st[smc_pkg::IRQ_RX_DONE] = 1'b1;
    end
    if (rx_err && cksum_en) begin
      next_irq_st[smc_pkg::IRQ_RX_ERR] = 1'b1;
    end
    if (tx_start && !tx_busy) begin
      next_irq_st[smc_pkg::IRQ_TX_DONE] = 1'b1;
    end
    if (move_done) begin
      next_irq_st[smc_pkg::IRQ_MOVE_DONE] = 1'b1;
    end
    next_irq = |(next_irq_st & next_irq_mk);
    next_drv_rst_n = (next_rst_cnt == 24'h000000);
    // ready low while busy or a move runs
    next_ready = !(next_ctrl[smc_pkg::CTRL_BUSY] || next_steps_left != 16'h0000 || st != SMC_ST_IDLE);
  end

  // step sequencer
  assign move_done = (st == SMC_ST_HOLD) && (st_cnt == 9'h000) && (steps_left == 16'h0000);

  always_comb begin
    next_st       = st;
    next_st_cnt   = (st_cnt != 9'h000) ? st_cnt - 9'h001 : st_cnt;
    next_step_clk = 1'b1;
    next_dir      = DIR_O;
    unique case (st)
      SMC_ST_IDLE: begin
        if (steps_left != 16'h0000 && enable_s && DRV_RST_N_O) begin
          next_dir    = ctrl[smc_pkg::CTRL_DIR];
          next_st     = SMC_ST_SETUP;
          next_st_cnt = 9'(smc_pkg::DIR_SETUP_CYC - 1);
        end
      end
      SMC_ST_SETUP: begin
        if (st_cnt == 9'h000) begin
          next_st       = SMC_ST_PULSE;
          next_st_cnt   = 9'(smc_pkg::STEP_PULSE_CYC - 1);
          next_step_clk = 1'b0;
        end
      end
      SMC_ST_PULSE: begin
        if (st_cnt == 9'h000) begin
          next_st     = SMC_ST_HOLD;
          next_st_cnt = 9'(smc_pkg::DIR_SETUP_CYC - 1);
        end else begin
          next_step_clk = 1'b0;
        end
      end
      SMC_ST_HOLD: begin
        if (st_cnt == 9'h000) begin
          next_st = SMC_ST_IDLE;
        end
      end
    endcase
    next_moving  = (steps_left != 16'h0000) || (next_st != SMC_ST_IDLE);
    next_ramping = next_moving && ctrl[smc_pkg::CTRL_RAMP];
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      latch_cnt          <= 2'h0;
      proto_addr         <= 3'h7;
      baud_code          <= 3'h7;
      cksum_en           <= 1'b1;
      recall_n           <= 1'b1;
      AUTORECALL_START_O <= 1'b0;
      ctrl               <= 4'h0;
      irq_st             <= '0;
      irq_mk             <= '0;
      rst_cnt            <= DRV_RST_CYC[23:0];
      DRV_RST_N_O        <= 1'b0;
      tx_data            <= 7'h00;
      tx_start           <= 1'b0;
      steps_left         <= 16'h0000;
      st                 <= SMC_ST_IDLE;
      st_cnt             <= 9'h000;
      STEP_CLK_O         <= 1'b1;
      DIR_O              <= 1'b0;
      MOVING_FLAG_O      <= 1'b0;
      RAMPING_FLAG_O     <= 1'b0;
      READY_FLAG_O       <= 1'b0;
      READY_FLAG_OE_N_O  <= 1'b1;
      IRQ_O              <= 1'b0;
      TXD_O              <= 1'b1;
      REG_RDATA_O        <= 32'h0000_0000;
    end else if (CE_I) begin
      latch_cnt          <= next_latch_cnt;
      proto_addr         <= next_proto_addr;
      baud_code          <= next_baud_code;
      cksum_en           <= next_cksum_en;
      recall_n           <= next_recall_n;
      AUTORECALL_START_O <= next_recall_start;
      ctrl               <= next_ctrl;
      irq_st             <= next_irq_st;
      irq_mk             <= next_irq_mk;
      rst_cnt            <= next_rst_cnt;
      DRV_RST_N_O        <= next_drv_rst_n;
      tx_data            <= next_tx_data;
      tx_start           <= next_tx_start;
      steps_left         <= next_steps_left;
      st                 <= next_st;
      st_cnt             <= next_st_cnt;
      STEP_CLK_O         <= next_step_clk;
      DIR_O              <= next_dir;
      MOVING_FLAG_O      <= next_moving;
      RAMPING_FLAG_O     <= next_ramping;
      // open collector: enable low pulls line low
      READY_FLAG_O       <= 1'b0;
      READY_FLAG_OE_N_O  <= next_ready;
      IRQ_O              <= next_irq;
      TXD_O              <= txd;
      REG_RDATA_O        <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ### src/smc_pkg.sv
// package of constants for the stepper controller pin interface
`default_nettype none
package smc_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  // driver reset low time after power-on or position-counter init, in ns
  localparam int unsigned DRV_RST_NS      = 400_000;
  localparam int unsigned DRV_RST_CYC     = DRV_RST_NS / 5;
  // step pulse low time, in ns
  localparam int unsigned STEP_PULSE_PS   = 1_700;
  localparam int unsigned STEP_PULSE_CYC  = (STEP_PULSE_PS * 1000 + 4999) / 5000;
  // direction settle time before and after each step pulse, in cycles
  localparam int unsigned DIR_SETUP_CYC   = 4;
  // oversampling factor of the serial port
  localparam int unsigned UART_OVS        = 16;
  // serial frame: 1 start, 7 data, odd parity, 2 stop
  localparam int unsigned UART_DATA_BITS  = 7;
  localparam int unsigned UART_FRAME_BITS = 11;

  // interrupt status and mask bit positions
  localparam int unsigned IRQ_RX_DONE     = 0;
  localparam int unsigned IRQ_TX_DONE     = 1;
  localparam int unsigned IRQ_MOVE_DONE   = 2;
  localparam int unsigned IRQ_RX_ERR      = 3;
  localparam int unsigned IRQ_BITS        = 4;

  // register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_ST = 4'h2;
  localparam logic [3:0] REG_IRQ_MK = 4'h3;
  localparam logic [3:0] REG_STRAPS = 4'h4;
  localparam logic [3:0] REG_TXDATA = 4'h5;
  localparam logic [3:0] REG_RXDATA = 4'h6;
  localparam logic [3:0] REG_STEP   = 4'h7;

  // control register fields
  localparam int unsigned CTRL_BUSY     = 0;
  localparam int unsigned CTRL_RAMP     = 1;
  localparam int unsigned CTRL_DIR      = 2;
  localparam int unsigned CTRL_INIT_POS = 3;

  // slowest and fastest serial rate of the baud straps, in bit/s
  localparam int unsigned BAUD_LOW  = 110;
  localparam int unsigned BAUD_HIGH = 9600;

  // clock cycles per oversample tick for a baud strap code; open straps give the fastest rate
  function automatic logic [16:0] baud_div(input logic [2:0] code, input int unsigned clk_hz);
    int unsigned rate;
    unique case (code)
      3'h0: rate = BAUD_LOW;
      3'h1: rate = 300;
      3'h2: rate = 600;
      3'h3: rate = 1200;
      3'h4: rate = 2400;
      3'h5: rate = 4800;
      default: rate = BAUD_HIGH;
    endcase
    baud_div = 17'(clk_hz / (UART_OVS * rate));
  endfunction

endpackage
`default_nettype wire

// ### src/smc_uart.sv
// serial port: 7 data bits, odd parity, two stop bits, oversampled receive
`timescale 1ns/1ps
`default_nettype none
module smc_uart (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [16:0] div_i,
  input  wire logic        rxd_i,
  input  wire logic        tx_start_i,
  input  wire logic [6:0]  tx_data_i,
  output logic             txd_o,
  output logic             tx_busy_o,
  output logic             rx_valid_o,
  output logic             rx_err_o,
  output logic [6:0]       rx_data_o
);

  logic [16:0] div_cnt, next_div_cnt;
  logic        tick;
  logic [3:0]  tx_ovs, next_tx_ovs, rx_ovs, next_rx_ovs;
  logic [3:0]  tx_bit, next_tx_bit, rx_bit, next_rx_bit;
  logic [10:0] tx_sh, next_tx_sh;
  logic [9:0]  rx_sh, next_rx_sh;
  logic        rx_act, next_rx_act;
  logic        next_txd, next_tx_busy, next_rx_valid, next_rx_err;
  logic [6:0]  next_rx_data;

  assign tick = (div_cnt == 17'h00000);

  always_comb begin
    next_div_cnt  = tick ? div_i - 17'h00001 : div_cnt - 17'h00001;
    next_tx_ovs   = tx_ovs;
    next_tx_bit   = tx_bit;
    next_tx_sh    = tx_sh;
    next_txd      = txd_o;
    next_tx_busy  = tx_busy_o;
    next_rx_ovs   = rx_ovs;
    next_rx_bit   = rx_bit;
    next_rx_sh    = rx_sh;
    next_rx_act   = rx_act;
    next_rx_valid = 1'b0;
    next_rx_err   = 1'b0;
    next_rx_data  = rx_data_o;
    if (tx_start_i && !tx_busy_o) begin
      // stop, stop, parity, data lsb first, start
      next_tx_sh   = {2'b11, ~(^tx_data_i), tx_data_i, 1'b0};
      next_tx_busy = 1'b1;
      next_tx_ovs  = 4'h0;
      next_tx_bit  = 4'h0;
    end else if (tx_busy_o && tick) begin
      next_tx_ovs = tx_ovs + 4'h1;
      if (tx_ovs == 4'h0) begin
        next_txd = tx_sh[0];
        next_tx_sh = {1'b1, tx_sh[10:1]};
      end
      if (tx_ovs == 4'hF) begin
        next_tx_bit = tx_bit + 4'h1;
        if (tx_bit == 4'(smc_pkg::UART_FRAME_BITS - 1)) begin
          next_tx_busy = 1'b0;
        end
      end
    end
    if (tick) begin
      if (!rx_act) begin
        if (!rxd_i) begin
          next_rx_act = 1'b1;
          next_rx_ovs = 4'h1;
          next_rx_bit = 4'h0;
        end
      end else begin
        next_rx_ovs = rx_ovs + 4'h1;
        if (rx_ovs == 4'h8) begin
          if (rx_bit == 4'h0 && rxd_i) begin
            next_rx_act = 1'b0;  // false start
          end else if (rx_bit == 4'h9) begin
            next_rx_act   = 1'b0;
            next_rx_valid = 1'b1;
            next_rx_data  = rx_sh[8:2];
            next_rx_err   = !rxd_i || !(^rx_sh[9:2]);
          end else begin
            next_rx_sh = {rxd_i, rx_sh[9:1]};
          end
          next_rx_bit = rx_bit + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt    <= 17'h00000;
      tx_ovs     <= 4'h0;
      tx_bit     <= 4'h0;
      tx_sh      <= 11'h7FF;
      txd_o      <= 1'b1;
      tx_busy_o  <= 1'b0;
      rx_ovs     <= 4'h0;
      rx_bit     <= 4'h0;
      rx_sh      <= 10'h000;
      rx_act     <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_err_o   <= 1'b0;
      rx_data_o  <= 7'h00;
    end else if (ce_i) begin
      div_cnt    <= next_div_cnt;
      tx_ovs     <= next_tx_ovs;
      tx_bit     <= next_tx_bit;
      tx_sh      <= next_tx_sh;
      txd_o      <= next_txd;
      tx_busy_o  <= next_tx_busy;
      rx_ovs     <= next_rx_ovs;
      rx_bit     <= next_rx_bit;
      rx_sh      <= next_rx_sh;
      rx_act     <= next_rx_act;
      rx_valid_o <= next_rx_valid;
      rx_err_o   <= next_rx_err;
      rx_data_o  <= next_rx_data;
    end
  end

endmodule
`default_nettype wire

// ### bench/smc_properties.sv
// concurrent checks on the pins of the stepper controller top
`timescale 1ns/1ps
`default_nettype none
module smc_properties #(
  parameter int unsigned DRV_RST_CYC = 20
) (
  input wire logic        CLOCK_I,
  input wire logic        SYS_RST_I,
  input wire logic        AUTORECALL_STRAP_I,
  input wire logic        ENABLE_I,
  input wire logic        TXD_O,
  input wire logic        READY_FLAG_O,
  input wire logic        READY_FLAG_OE_N_O,
  input wire logic        MOVING_FLAG_O,
  input wire logic        RAMPING_FLAG_O,
  input wire logic        DIR_O,
  input wire logic        DRV_RST_N_O,
  input wire logic        STEP_CLK_O,
  input wire logic        AUTORECALL_START_O
);
  int low_cnt;
  int next_low_cnt;
  int drv_cnt;
  int next_drv_cnt;
  int en_cnt;
  int next_en_cnt;

  // cycles of step low, driver reset low, and enable low
  always_comb begin
    next_low_cnt = STEP_CLK_O ? 0 : low_cnt + 1;
    next_drv_cnt = DRV_RST_N_O ? 0 : drv_cnt + 1;
    next_en_cnt  = ENABLE_I ? 0 : ((en_cnt < 15) ? en_cnt + 1 : en_cnt);
  end
  always_ff @(posedge CLOCK_I) begin
    low_cnt <= SYS_RST_I ? 0 : next_low_cnt;
    drv_cnt <= SYS_RST_I ? 0 : next_drv_cnt;
    en_cnt  <= SYS_RST_I ? 0 : next_en_cnt;
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence step_gap_s;
    STEP_CLK_O [*5];
  endsequence
  sequence tx_bit_s;
    !TXD_O [*8];
  endsequence

  step_width_a: assert property ($rose(STEP_CLK_O) |-> low_cnt == smc_pkg::STEP_PULSE_CYC)
    else $error("step pulse width off");
  step_gap_a: assert property ($rose(STEP_CLK_O) |-> step_gap_s)
    else $error("step pulses too close");
  dir_steady_a: assert property (!STEP_CLK_O |-> $stable(DIR_O))
    else $error("direction moved during step");
  step_enable_a: assert property ($fell(STEP_CLK_O) |-> en_cnt < 12)
    else $error("step issued while enable low");
  moving_step_a: assert property (!STEP_CLK_O |-> MOVING_FLAG_O)
    else $error("step without moving flag");
  ramp_moving_a: assert property (RAMPING_FLAG_O |-> MOVING_FLAG_O)
    else $error("ramping flag at rest");
  ready_busy_a: assert property (!STEP_CLK_O |-> !READY_FLAG_OE_N_O && !READY_FLAG_O)
    else $error("ready line released during step");
  drv_width_a: assert property ($rose(DRV_RST_N_O) |-> drv_cnt inside {[DRV_RST_CYC - 1:DRV_RST_CYC + 1]})
    else $error("driver reset width off");
  tx_bit_a: assert property ($fell(TXD_O) |-> tx_bit_s)
    else $error("serial bit too short");
  recall_pulse_a: assert property (AUTORECALL_START_O |-> !AUTORECALL_STRAP_I ##1 !AUTORECALL_START_O)
    else $error("autorecall start pulse wrong");
endmodule

bind smc_top smc_properties #(.DRV_RST_CYC(DRV_RST_CYC)) i_smc_properties (
  .CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .AUTORECALL_STRAP_I(AUTORECALL_STRAP_I), .ENABLE_I(ENABLE_I),
  .TXD_O(TXD_O), .READY_FLAG_O(READY_FLAG_O), .READY_FLAG_OE_N_O(READY_FLAG_OE_N_O),
  .MOVING_FLAG_O(MOVING_FLAG_O), .RAMPING_FLAG_O(RAMPING_FLAG_O), .DIR_O(DIR_O), .DRV_RST_N_O(DRV_RST_N_O),
  .STEP_CLK_O(STEP_CLK_O), .AUTORECALL_START_O(AUTORECALL_START_O));
`default_nettype wire

// ### bench/smc_far_side.sv
// host serial line and sequencer-driver model facing the controller
`timescale 1ns/1ps
`default_nettype none
module smc_far_side (
  input  wire logic       clk_i,
  input  wire logic       step_clk_i,
  input  wire logic       block_i,
  input  wire logic [7:0] confirm_i,
  output logic            enable_o,
  output logic            rxd_o,
  output int              steps_o
);
  logic step_q;
  int   hold;

  initial begin
    enable_o = 1'b1;
    rxd_o = 1'b1;
    steps_o = 0;
    step_q = 1'b1;
    hold = 0;
  end

  always @(posedge clk_i) begin
    step_q <= step_clk_i;
    if (step_clk_i && !step_q) steps_o <= steps_o + 1;
    if (!step_clk_i) hold <= confirm_i;
    else if (hold != 0) hold <= hold - 1;
    enable_o <= !block_i && hold == 0 && (step_clk_i || confirm_i == 8'h00);
  end

  // one frame: start, 7 data lsb first, odd parity, 2 stop
  task automatic send_char(input logic [6:0] ch, input int bit_cyc);
    logic [10:0] f;
    f = {2'b11, ~^ch, ch, 1'b0};
    for (int j = 0; j < 11; j++) begin
      rxd_o <= f[j];
      repeat (bit_cyc) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ### bench/smc_top_bench.sv
// self-checking bench of the stepper controller pin interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
`define WAIT_UNTIL(c, n) begin for (k = 0; k < (n) && !(c); k++) @(posedge clk); if (!(c)) timed_out(); end
module smc_top_bench;
  // a slower nominal clock keeps frames short; 9600 bit/s from strap code 6
  localparam int TB_CLK_HZ = 50_000_000;
  localparam int BIT_CYC = 16 * (TB_CLK_HZ / (16 * 9600));
  logic        clk, rst, cksum, recall_n, enable, rxd, txd, rdy, rdy_oe_n;
  logic        moving, ramping, dir, drv_rst_n, step_clk, recall, irq;
  logic        wr, rd, block, saw_ramp, saw_recall, dir_b, ramp_b, ce;
  logic [2:0]  proto, baud;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, rd_val;
  logic [7:0]  confirm;
  logic [6:0]  ch, tx_ch;
  logic [10:0] frame;
  int          steps, s0, n, k, i, n_mismatch, checked;

  smc_top #(.DRV_RST_CYC(20), .CLK_HZ(TB_CLK_HZ)) i_smc_top (
    .CLOCK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .PROTO_ADDR_STRAP_I(proto), .BAUD_STRAP_I(baud),
    .CHECKSUM_STRAP_I(cksum), .AUTORECALL_STRAP_I(recall_n), .ENABLE_I(enable), .RXD_I(rxd), .TXD_O(txd),
    .READY_FLAG_O(rdy), .READY_FLAG_OE_N_O(rdy_oe_n), .MOVING_FLAG_O(moving), .RAMPING_FLAG_O(ramping),
    .DIR_O(dir), .DRV_RST_N_O(drv_rst_n), .STEP_CLK_O(step_clk), .AUTORECALL_START_O(recall), .IRQ_O(irq),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata));
  smc_far_side i_smc_far_side (.clk_i(clk), .step_clk_i(step_clk), .block_i(block), .confirm_i(confirm),
    .enable_o(enable), .rxd_o(rxd), .steps_o(steps));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ramping) saw_ramp <= 1'b1;
    if (recall) saw_recall <= 1'b1;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic timed_out;
    n_mismatch++;
    report_and_stop();
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  initial begin
    void'($urandom(64));
    rst = 1'b1;
    proto = 3'($urandom);
    baud = 3'h6;
    cksum = 1'b1;
    recall_n = 1'b0;
    {addr, wdata, wr, rd, block, saw_ramp, saw_recall} = '0;
    ce = 1'b1;
    confirm = 8'h00;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    rd_reg(smc_pkg::REG_STRAPS, rd_val);
    `CHK(rd_val, {24'h0, recall_n, cksum, baud, proto})
    `CHK(saw_recall, 1'b1)
    $display("test straps done");
    `WAIT_UNTIL(drv_rst_n, 100)
    wr_reg(smc_pkg::REG_CTRL, 32'h8);
    repeat (3) @(posedge clk);
    `CHK(drv_rst_n, 1'b0)
    `WAIT_UNTIL(drv_rst_n, 100)
    $display("test driver reset done");
    for (i = 0; i < 3; i++) begin
      dir_b = 1'($urandom);
      ramp_b = 1'($urandom);
      n = 1 + $urandom % 3;
      confirm <= (i == 0) ? 8'h00 : 8'($urandom % 40);
      saw_ramp = 1'b0;
      s0 = steps;
      wr_reg(smc_pkg::REG_CTRL, {28'h0, 1'b0, dir_b, ramp_b, 1'b0});
      wr_reg(smc_pkg::REG_STEP, 32'(n));
      `WAIT_UNTIL(moving, 10)
      repeat (3) @(posedge clk);
      `CHK(rdy_oe_n, 1'b0)
      `WAIT_UNTIL(!moving, 3000)
      repeat (3) @(posedge clk);
      `CHK(steps - s0, n)
      `CHK(dir, dir_b)
      `CHK(saw_ramp, ramp_b)
      `CHK(rdy_oe_n, 1'b1)
    end
    $display("test moves done");
    block <= 1'b1;
    repeat (4) @(posedge clk);
    s0 = steps;
    wr_reg(smc_pkg::REG_STEP, 32'h1);
    repeat (60) @(posedge clk);
    `CHK(steps - s0, 0)
    `CHK(step_clk, 1'b1)
    block <= 1'b0;
    `WAIT_UNTIL(!moving, 1000)
    `CHK(steps - s0, 1)
    ce <= 1'b0;
    wr_reg(smc_pkg::REG_CTRL, 32'h1);
    ce <= 1'b1;
    `CHK(rdy_oe_n, 1'b1)
    wr_reg(smc_pkg::REG_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK({rdy, rdy_oe_n}, 2'b00)
    wr_reg(smc_pkg::REG_CTRL, 32'h0);
    $display("test enable and busy done");
    rd_reg(smc_pkg::REG_IRQ_ST, rd_val);
    wr_reg(smc_pkg::REG_IRQ_MK, 32'h0);
    ch = 7'($urandom);
    tx_ch = 7'($urandom);
    `CHK(txd, 1'b1)
    wr_reg(smc_pkg::REG_TXDATA, {25'h0, tx_ch});
    fork
      i_smc_far_side.send_char(ch, BIT_CYC);
      begin
        `WAIT_UNTIL(!txd, 2000)
        repeat (BIT_CYC / 2) @(posedge clk);
        for (i = 0; i < 11; i++) begin
          frame[i] = txd;
          repeat (BIT_CYC) @(posedge clk);
        end
      end
    join
    `CHK(frame, {2'b11, ~^tx_ch, tx_ch, 1'b0})
    `CHK(irq, 1'b0)
    wr_reg(smc_pkg::REG_IRQ_MK, 32'h3);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    rd_reg(smc_pkg::REG_RXDATA, rd_val);
    `CHK(rd_val, {25'h0, ch})
    rd_reg(smc_pkg::REG_IRQ_ST, rd_val);
    `CHK(rd_val, 32'h3)
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rd_reg(4'hF, rd_val);
    `CHK(rd_val, 32'h0)
    $display("test serial and interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
